// ==== logic/crc_byte_buf.sv ====
// crc_byte_buf: two-entry byte buffer with valid/ready on both sides.
// assumes a single clock and an asynchronous active-high reset.
`timescale 1ns/1ns
module crc_byte_buf
  import crc_pkg::*;
(
  input wire logic sys_clk_i, // clock
  input wire logic rst_i, // async reset
  input wire logic [7:0] in_data_i, // byte in
  input wire logic in_valid_i, // byte offered
  output logic in_ready_o, // room for a byte
  output logic [7:0] out_data_o, // byte out
  output logic out_valid_o, // byte available
  input wire logic out_ready_i, // drain side takes it
  input wire logic flush_i // drop contents
);

  logic [7:0] mem_reg [CRC_BUF_DEPTH];
  logic [7:0] mem_next [CRC_BUF_DEPTH];
  logic [1:0] cnt_reg;
  logic [1:0] cnt_next;

  assign in_ready_o = (cnt_reg != 2'd2);
  assign out_valid_o = (cnt_reg != 2'd0);
  assign out_data_o = mem_reg[0];

  always_comb begin
    logic push;
    logic pop;
    push = in_valid_i && in_ready_o;
    pop = out_valid_o && out_ready_i;
    mem_next[0] = mem_reg[0];
    mem_next[1] = mem_reg[1];
    cnt_next = cnt_reg;
    if (flush_i) begin
      cnt_next = 2'd0;
    end else begin
      if (pop) begin
        mem_next[0] = mem_reg[1];
      end
      if (push) begin
        if (cnt_reg == 2'd0 || (cnt_reg == 2'd1 && pop)) begin
          mem_next[0] = in_data_i;
        end else begin
          mem_next[1] = in_data_i;
        end
      end
      cnt_next = 2'(cnt_reg + {1'b0, push} - {1'b0, pop});
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mem_reg[0] <= 8'h00;
      mem_reg[1] <= 8'h00;
      cnt_reg <= 2'd0;
    end else begin
      mem_reg <= mem_next;
      cnt_reg <= cnt_next;
    end
  end

  a_buf_no_over: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    cnt_reg <= 2'd2)
    else $error("buffer count above depth");

endmodule : crc_byte_buf

// ==== logic/crc_checksum_gen.sv ====
// crc_checksum_gen: byte-wide crc-16/crc-32 generator fed by io, dma or flash.
// assumes the flash answers a read one cycle after fl_rd_o with fl_data_i.
`timescale 1ns/1ns
module crc_checksum_gen
  import crc_pkg::*;
(
  input wire logic sys_clk_i, // 50 MHz clock
  input wire logic rst_i, // async reset, active high
  input wire logic [3:0] src_sel_i, // one-hot source select
  input wire logic poly32_sel_i, // software picks crc-32
  input wire logic reset_sum_i, // pulse: restart checksum
  input wire logic [7:0] io_data_i, // cpu written byte
  input wire logic io_wr_i, // cpu write strobe
  output logic io_ready_o, // cpu write can be taken
  input wire logic [7:0] dma_data_i, // dma channel byte
  input wire logic dma_valid_i, // dma byte present
  output logic dma_ready_o, // dma may proceed
  input wire logic flash_start_i, // pulse: start flash sweep
  input wire logic flash_range_i, // use range not full array
  input wire logic [23:0] flash_first_i, // range first address
  input wire logic [23:0] flash_last_i, // range last address
  output logic fl_rd_o, // flash read strobe
  output logic [23:0] fl_addr_o, // flash read address
  input wire logic [7:0] fl_data_i, // flash data, one cycle later
  output logic [31:0] checksum_o, // readable result
  output logic busy_o, // bytes pending or sweep running
  output logic zero_o // remainder is zero
);

  function automatic logic [31:0] crc_step(input logic [31:0] crc, input logic [7:0] b,
                                           input logic wide);
    logic [31:0] c;
    c = crc;
    for (int i = 0; i < 8; i++) begin
      if (wide) begin
        if (c[31] ^ b[7 - i]) begin
          c = {c[30:0], 1'b0} ^ CRC_POLY32;
        end else begin
          c = {c[30:0], 1'b0};
        end
      end else begin
        if (c[15] ^ b[7 - i]) begin
          c = {16'h0000, c[14:0], 1'b0} ^ {16'h0000, CRC_POLY16};
        end else begin
          c = {16'h0000, c[14:0], 1'b0};
        end
      end
    end
    return c;
  endfunction : crc_step

  function automatic logic [31:0] bit_rev32(input logic [31:0] v);
    logic [31:0] r;
    r = 32'h00000000;
    for (int i = 0; i < 32; i++) begin
      r[i] = v[31 - i];
    end
    return r;
  endfunction : bit_rev32

  crc_src_t src;
  logic wide;
  logic [31:0] crc_reg;
  logic [31:0] crc_next;
  crc_fs_t fs_reg;
  crc_fs_t fs_next;
  logic [23:0] addr_reg;
  logic [23:0] addr_next;
  logic [23:0] last_reg;
  logic [23:0] last_next;
  logic rd_reg;
  logic rd_next;
  logic [7:0] in_byte;
  logic in_valid;
  logic in_ready;
  logic [7:0] buf_byte;
  logic buf_valid;
  logic [31:0] res_reg;
  logic [31:0] res_next;
  logic zero_reg;
  logic zero_next;

  assign src = crc_src_t'(src_sel_i);
  assign wide = (src == CRC_SRC_FLASH) ? 1'b1 : poly32_sel_i;

  // source mux: only the selected source reaches the buffer
  always_comb begin
    in_byte = 8'h00;
    in_valid = 1'b0;
    case (src)
      CRC_SRC_IO: begin
        in_byte = io_data_i;
        in_valid = io_wr_i;
      end
      CRC_SRC_DMA: begin
        in_byte = dma_data_i;
        in_valid = dma_valid_i;
      end
      CRC_SRC_FLASH: begin
        in_byte = fl_data_i;
        in_valid = rd_reg;
      end
      default: begin
        in_byte = 8'h00;
        in_valid = 1'b0;
      end
    endcase
  end

  assign io_ready_o = in_ready && (src == CRC_SRC_IO);
  // dma is throttled by buffer room so a stall never loses a byte
  assign dma_ready_o = in_ready && (src == CRC_SRC_DMA);

  crc_byte_buf i_crc_byte_buf (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .in_data_i(in_byte),
    .in_valid_i(in_valid),
    .in_ready_o(in_ready),
    .out_data_o(buf_byte),
    .out_valid_o(buf_valid),
    .out_ready_i(1'b1),
    .flush_i(reset_sum_i)
  );

  // flash sweep; a read is issued only with buffer room and no read already in flight
  always_comb begin
    fs_next = fs_reg;
    addr_next = addr_reg;
    last_next = last_reg;
    rd_next = 1'b0;
    case (fs_reg)
      CRC_FS_IDLE: begin
        if (flash_start_i && src == CRC_SRC_FLASH) begin
          addr_next = flash_range_i ? flash_first_i : CRC_ADDR_RESET;
          last_next = flash_range_i ? flash_last_i : CRC_FLASH_SIZE - 24'h000001;
          fs_next = CRC_FS_RUN;
        end
      end
      CRC_FS_RUN: begin
        if (src != CRC_SRC_FLASH || reset_sum_i) begin
          fs_next = CRC_FS_IDLE;
        end else if (in_ready && !rd_reg) begin
          rd_next = 1'b1;
          if (addr_reg == last_reg) begin
            fs_next = CRC_FS_DONE;
          end else begin
            addr_next = addr_reg + 24'h000001;
          end
        end
      end
      CRC_FS_DONE: begin
        fs_next = CRC_FS_IDLE;
      end
      default: begin
        fs_next = CRC_FS_IDLE;
      end
    endcase
  end

  assign fl_rd_o = rd_next;
  assign fl_addr_o = addr_reg;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      fs_reg <= CRC_FS_IDLE;
      addr_reg <= CRC_ADDR_RESET;
      last_reg <= CRC_ADDR_RESET;
      rd_reg <= 1'b0;
    end else begin
      fs_reg <= fs_next;
      addr_reg <= addr_next;
      last_reg <= last_next;
      rd_reg <= rd_next;
    end
  end

  // remainder update, one byte per cycle at most
  always_comb begin
    crc_next = crc_reg;
    if (reset_sum_i) begin
      crc_next = wide ? CRC_INIT32 : CRC_INIT16;
    end else if (buf_valid) begin
      crc_next = crc_step(crc_reg, buf_byte, wide);
    end
    // reflected and inverted view of the remainder for crc-32 reads
    res_next = wide ? ~bit_rev32(crc_next) : {16'h0000, crc_next[15:0]};
    zero_next = wide ? (crc_next == 32'h00000000) : (crc_next[15:0] == 16'h0000);
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      crc_reg <= CRC_RESET_VALUE;
      res_reg <= CRC_RESET_VALUE;
      zero_reg <= 1'b0;
    end else begin
      crc_reg <= crc_next;
      res_reg <= res_next;
      zero_reg <= zero_next;
    end
  end

  assign checksum_o = res_reg;
  assign zero_o = zero_reg;
  assign busy_o = buf_valid || (fs_reg == CRC_FS_RUN) || rd_reg;

  a_flash_forces_wide: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    src == CRC_SRC_FLASH |-> wide)
    else $error("flash source without crc-32");

  a_reset_poly_narrow: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (src != CRC_SRC_FLASH && !poly32_sel_i) |-> !wide)
    else $error("16-bit mode not kept");

  a_byte_step_once: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (buf_valid && !reset_sum_i) |=> crc_reg == crc_step($past(crc_reg), $past(buf_byte),
                                               $past(wide)))
    else $error("remainder not advanced by one byte");

  a_idle_holds_sum: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (!buf_valid && !reset_sum_i) |=> $stable(crc_reg))
    else $error("remainder changed with no byte");

  a_wide_result_form: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    wide ##1 wide |-> checksum_o == ~bit_rev32(crc_reg))
    else $error("crc-32 result not reflected and inverted");

  a_narrow_result: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !wide ##1 !wide |-> checksum_o == {16'h0000, crc_reg[15:0]})
    else $error("crc-16 result mismatch");

  a_zero_flag: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    wide ##1 wide |-> zero_o == (crc_reg == 32'h00000000))
    else $error("zero flag wrong");

  a_zero_narrow: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !wide ##1 !wide |-> zero_o == (crc_reg[15:0] == 16'h0000))
    else $error("crc-16 zero flag wrong");

  a_dma_only_selected: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    src != CRC_SRC_DMA |-> !dma_ready_o)
    else $error("dma accepted while not selected");

  a_flash_read_next: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (fl_rd_o && src == CRC_SRC_FLASH && !reset_sum_i) |=> in_valid)
    else $error("flash read byte not offered");

  a_dma_byte_taken: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (dma_valid_i && dma_ready_o && !reset_sum_i) |=> buf_valid)
    else $error("dma byte not queued");

endmodule : crc_checksum_gen

// ==== logic/crc_pkg.sv ====
// crc_pkg: constants and types shared by the checksum generator files.
// assumes nothing of its surroundings; pure definitions.
package crc_pkg;

  localparam logic [15:0] CRC_POLY16 = 16'h1021;
  localparam logic [31:0] CRC_POLY32 = 32'h04c11db7;
  localparam logic [31:0] CRC_INIT16 = 32'h0000ffff;
  localparam logic [31:0] CRC_INIT32 = 32'hffffffff;
  localparam logic [31:0] CRC_RESET_VALUE = 32'h00000000;
  localparam logic [23:0] CRC_FLASH_SIZE = 24'h060000;
  localparam logic [23:0] CRC_ADDR_RESET = 24'h000000;
  localparam int CRC_BUF_DEPTH = 2;

  // input source select; none leaves the generator idle
  typedef enum logic [3:0] {
    CRC_SRC_NONE  = 4'b0001,
    CRC_SRC_IO    = 4'b0010,
    CRC_SRC_DMA   = 4'b0100,
    CRC_SRC_FLASH = 4'b1000
  } crc_src_t;

  // flash sweep state machine
  typedef enum logic [2:0] {
    CRC_FS_IDLE = 3'b001,
    CRC_FS_RUN  = 3'b010,
    CRC_FS_DONE = 3'b100
  } crc_fs_t;

endpackage : crc_pkg

// ==== test/crc_checksum_generator_tb.sv ====
// crc_checksum_generator_tb: self-checking bench for the checksum generator.
// assumes the flash model answers reads; io and dma are driven here.
`timescale 1ns/1ns
module crc_checksum_generator_tb;
  import crc_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] src_sel_i = CRC_SRC_NONE;
  logic poly32_sel_i = 1'b0;
  logic reset_sum_i = 1'b0;
  logic [7:0] io_data_i = 8'h00;
  logic io_wr_i = 1'b0;
  logic [7:0] dma_data_i = 8'h00;
  logic dma_valid_i = 1'b0;
  logic flash_start_i = 1'b0;
  logic flash_range_i = 1'b0;
  logic [23:0] flash_first_i = 24'h000000;
  logic [23:0] flash_last_i = 24'h000000;
  logic io_ready_o, dma_ready_o, fl_rd_o, busy_o, zero_o;
  logic [23:0] fl_addr_o;
  logic [7:0] fl_data_i;
  logic [31:0] checksum_o;
  int error_cnt = 0;
  int compares = 0;
  int cyc = 0;
  logic [7:0] q[$];

  crc_checksum_gen i_crc_checksum_gen (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .src_sel_i(src_sel_i), .poly32_sel_i(poly32_sel_i), .reset_sum_i(reset_sum_i),
    .io_data_i(io_data_i), .io_wr_i(io_wr_i), .io_ready_o(io_ready_o),
    .dma_data_i(dma_data_i), .dma_valid_i(dma_valid_i), .dma_ready_o(dma_ready_o),
    .flash_start_i(flash_start_i), .flash_range_i(flash_range_i),
    .flash_first_i(flash_first_i), .flash_last_i(flash_last_i), .fl_rd_o(fl_rd_o),
    .fl_addr_o(fl_addr_o), .fl_data_i(fl_data_i), .checksum_o(checksum_o),
    .busy_o(busy_o), .zero_o(zero_o));
  crc_flash_model i_crc_flash_model (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .fl_rd_i(fl_rd_o), .fl_addr_i(fl_addr_o), .fl_data_o(fl_data_i));

  initial begin
    forever #10 sys_clk_i = ~sys_clk_i;
  end

  task automatic print_verdict();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict

  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      $display("CHECK FAILED %0t timeout", $time);
      print_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic tick();
    @(posedge sys_clk_i);
    #2;
  endtask : tick

  // bitwise msb-first division, independent of the design's own code
  function automatic logic [31:0] expect_sum(input logic [7:0] d[$], input logic w);
    logic [31:0] r;
    logic [31:0] o;
    r = w ? CRC_INIT32 : CRC_INIT16;
    foreach (d[k]) begin
      for (int i = 7; i >= 0; i--) begin
        if (w) r = {r[30:0], 1'b0} ^ ((r[31] ^ d[k][i]) ? CRC_POLY32 : 32'h0);
        else r = {16'h0, r[14:0], 1'b0} ^ ((r[15] ^ d[k][i]) ? {16'h0, CRC_POLY16} : 32'h0);
      end
    end
    for (int i = 0; i < 32; i++) o[i] = r[31-i];
    return w ? ~o : r;
  endfunction : expect_sum

  task automatic start(input logic [3:0] src, input logic w);
    src_sel_i = src;
    poly32_sel_i = w;
    reset_sum_i = 1'b1;
    tick();
    reset_sum_i = 1'b0;
    repeat (2) tick();
  endtask : start

  task automatic settle();
    int n;
    n = 0;
    while (busy_o !== 1'b0 && n < 200) begin
      tick();
      n++;
    end
    if (n == 200) begin
      error_cnt++;
      $display("CHECK FAILED %0t busy never dropped", $time);
    end
    repeat (3) tick();
  endtask : settle

  // back-to-back bytes, each held until the port says it can take it
  task automatic feed(input logic dma);
    int n;
    foreach (q[k]) begin
      // the other port is left alone so a junk writer stays active
      if (dma) begin
        dma_data_i = q[k];
        dma_valid_i = 1'b1;
      end else begin
        io_data_i = q[k];
        io_wr_i = 1'b1;
      end
      n = 0;
      while ((dma ? dma_ready_o : io_ready_o) !== 1'b1 && n < 50) begin
        tick();
        n++;
      end
      if (n == 50) begin
        error_cnt++;
        $display("CHECK FAILED %0t port never ready", $time);
      end
      tick();
    end
    dma_valid_i = 1'b0;
    io_wr_i = 1'b0;
    settle();
  endtask : feed

  task automatic t_io16();
    start(CRC_SRC_IO, 1'b0);
    q = '{8'h31, 8'h32, 8'h33, 8'h34, 8'h35, 8'h36, 8'h37, 8'h38, 8'h39};
    feed(1'b0);
    chk(checksum_o, 32'h000029b1, "io crc16");
  endtask : t_io16

  task automatic t_io32();
    start(CRC_SRC_IO, 1'b1);
    feed(1'b0);
    chk(checksum_o, expect_sum(q, 1'b1), "io crc32");
  endtask : t_io32

  // cpu keeps writing junk while dma owns the generator
  task automatic t_dma();
    start(CRC_SRC_DMA, 1'b1);
    io_data_i = 8'hee;
    io_wr_i = 1'b1;
    tick();
    chk(io_ready_o, 32'h0, "io ready under dma");
    chk(busy_o, 32'h0, "io write queued under dma");
    q = '{8'h00, 8'hff, 8'h5a, 8'ha5, 8'h80};
    feed(1'b1);
    chk(checksum_o, expect_sum(q, 1'b1), "dma crc32");
  endtask : t_dma

  task automatic t_zero();
    logic [31:0] e;
    start(CRC_SRC_IO, 1'b0);
    q = '{8'h12, 8'h34, 8'h56};
    e = expect_sum(q, 1'b0);
    q.push_back(e[15:8]);
    q.push_back(e[7:0]);
    feed(1'b0);
    chk(zero_o, 32'h1, "zero flag");
    chk(checksum_o, 32'h0, "zero remainder");
  endtask : t_zero

  // software asks for crc16 but flash must force crc32
  task automatic t_flash();
    start(CRC_SRC_FLASH, 1'b0);
    flash_range_i = 1'b1;
    flash_first_i = 24'h0001fc;
    flash_last_i = 24'h000203;
    q.delete();
    for (int a = 'h1fc; a <= 'h203; a++) q.push_back(a[7:0] ^ a[15:8] ^ 8'h3c);
    flash_start_i = 1'b1;
    tick();
    flash_start_i = 1'b0;
    tick();
    settle();
    chk(checksum_o, expect_sum(q, 1'b1), "flash range crc32");
  endtask : t_flash

  // a full-array sweep is far too long to finish; check its first reads, then abort
  task automatic t_flash_full();
    flash_range_i = 1'b0;
    flash_start_i = 1'b1;
    tick();
    flash_start_i = 1'b0;
    chk({fl_rd_o, fl_addr_o}, {8'h01, CRC_ADDR_RESET}, "full sweep first read");
    repeat (2) tick();
    chk({fl_rd_o, fl_addr_o}, {8'h01, CRC_ADDR_RESET + 24'h000001}, "full second read");
    reset_sum_i = 1'b1;
    tick();
    reset_sum_i = 1'b0;
    q.delete();
    chk(busy_o, 32'h0, "sweep aborted");
    chk(checksum_o, expect_sum(q, 1'b1), "crc32 restart value");
  endtask : t_flash_full

  initial begin
    repeat (4) @(posedge sys_clk_i);
    #1;
    chk(checksum_o, 32'h0, "reset checksum");
    chk({zero_o, busy_o}, 32'h0, "reset flags");
    tick();
    rst_i = 1'b0;
    tick();
    t_io16();
    t_io32();
    t_dma();
    t_zero();
    t_flash();
    t_flash_full();
    print_verdict();
  end
endmodule : crc_checksum_generator_tb

// ==== test/crc_flash_model.sv ====
// crc_flash_model: behavioural flash array seen by the checksum generator.
// assumes reads are strobed one cycle at a time; data shows the cycle after.
`timescale 1ns/1ns
module crc_flash_model
  import crc_pkg::*;
(
  input wire logic sys_clk_i, // clock
  input wire logic rst_i, // async reset
  input wire logic fl_rd_i, // read strobe
  input wire logic [23:0] fl_addr_i, // read address
  output logic [7:0] fl_data_o // byte, one cycle after strobe
);
  // content is a fixed function of the address so the bench can predict it
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      fl_data_o <= 8'h00;
    end else if (fl_rd_i) begin
      fl_data_o <= fl_addr_i[7:0] ^ fl_addr_i[15:8] ^ 8'h3c;
    end else begin
      // stale data toggles so a late sample never looks right by chance
      fl_data_o <= ~fl_data_o;
    end
  end
endmodule : crc_flash_model
